// [rtl/fivm_top.sv]
// interrupt vector masking for eight framers, with mask and vector registers
// Behaviour
// - set mask bit forces vector status zero
// - clear mask bit passes source through
// - first mask bits 11..8 mask framer 2
// - first mask bits 7..4 mask framer 1
// - first mask bits 3..0 mask framer 0
// - second mask bits 15..12 mask framer 7
// - second mask bits 11,10 framer 6 hdlc/elastic
// - framers 0-2 status read at 910
// - framer 6/7 status read at 911
// - mask registers at 902, 903, read/write
// - second mask bits 9,8 framer 6 rx/sync
// - second mask bits 7..0 framers 5, 4
// - first mask bits 15..12 mask framer 3
`include "fivm_defines.svh"

module fivm_top (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // host register port
   input wire logic [11:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata,
   output logic rd_valid,
   // per-framer interrupt sources, bit n is framer n
   input wire logic [7:0] src_hdlc,
   input wire logic [7:0] src_elastic,
   input wire logic [7:0] src_rxline,
   input wire logic [7:0] src_sync_ovf,
   // masked vector status, four bits per framer
   output logic [31:0] vec_status
);
   import fivm_pkg::*;

   // one decoder shared by the read and the write paths
   function automatic fivm_sel_t decode(input logic [11:0] a);
      fivm_sel_t s;
      s = FIVM_SEL_NONE;
      case (a)
         `FIVM_ADDR_MASK_LO: s = FIVM_SEL_MASK_LO;
         `FIVM_ADDR_MASK_HI: s = FIVM_SEL_MASK_HI;
         `FIVM_ADDR_VEC_LO: s = FIVM_SEL_VEC_LO;
         `FIVM_ADDR_VEC_HI: s = FIVM_SEL_VEC_HI;
         default: s = FIVM_SEL_NONE;
      endcase
      return s;
   endfunction

   fivm_top_state_t state_reg;
   fivm_top_state_t state_next;
   fivm_sel_t wr_sel;
   fivm_sel_t rd_sel;
   logic [15:0] mask_lo;
   logic [15:0] mask_hi;
   logic [31:0] mask_all;
   logic [31:0] raw_src;
   logic [31:0] masked_src;

   assign wr_sel = decode(addr);
   assign rd_sel = decode(addr);

   fivm_mask_reg u_mask_lo (
      .clk(clk),
      .rstn(rstn),
      .wr(wr_en && (wr_sel == FIVM_SEL_MASK_LO)),
      .wdata(wdata),
      .mask(mask_lo)
   );

   fivm_mask_reg u_mask_hi (
      .clk(clk),
      .rstn(rstn),
      .wr(wr_en && (wr_sel == FIVM_SEL_MASK_HI)),
      .wdata(wdata),
      .mask(mask_hi)
   );

   assign mask_all = {mask_hi, mask_lo};

   // named mask fields
   logic fr0_hdlc_mask, fr0_elastic_mask, fr0_rxline_mask, fr0_sync_ovf_mask;
   logic fr1_hdlc_mask, fr1_elastic_mask, fr1_rxline_mask, fr1_sync_ovf_mask;
   logic fr2_hdlc_mask, fr2_elastic_mask, fr2_rxline_mask, fr2_sync_ovf_mask;
   logic fr6_hdlc_mask, fr6_elastic_mask;
   logic fr7_hdlc_mask, fr7_elastic_mask, fr7_rxline_mask, fr7_sync_ovf_mask;
   logic fr0_sync_vector_status, fr1_hdlc_vector_status, fr2_hdlc_vector_status;
   logic fr6_elastic_vector_status, fr7_hdlc_vector_status;

   assign {fr0_hdlc_mask, fr0_elastic_mask, fr0_rxline_mask, fr0_sync_ovf_mask} = mask_lo[3:0];
   assign {fr1_hdlc_mask, fr1_elastic_mask, fr1_rxline_mask, fr1_sync_ovf_mask} = mask_lo[7:4];
   assign {fr2_hdlc_mask, fr2_elastic_mask, fr2_rxline_mask, fr2_sync_ovf_mask} = mask_lo[11:8];
   assign {fr6_hdlc_mask, fr6_elastic_mask} = mask_hi[11:10];
   assign {fr7_hdlc_mask, fr7_elastic_mask, fr7_rxline_mask, fr7_sync_ovf_mask} = mask_hi[15:12];

   assign fr0_sync_vector_status = state_reg.status[0];
   assign fr1_hdlc_vector_status = state_reg.status[7];
   assign fr2_hdlc_vector_status = state_reg.status[11];
   assign fr6_elastic_vector_status = state_reg.status[26];
   assign fr7_hdlc_vector_status = state_reg.status[31];

   // same nibble layout for every framer, so framers 3..5 follow too
   genvar g;
   generate
      for (g = 0; g < `FIVM_FRAMERS; g++) begin : g_fr
         assign raw_src[`FIVM_SRC_PER_FR*g + `FIVM_BIT_HDLC] = src_hdlc[g];
         assign raw_src[`FIVM_SRC_PER_FR*g + `FIVM_BIT_ELASTIC] = src_elastic[g];
         assign raw_src[`FIVM_SRC_PER_FR*g + `FIVM_BIT_RXLINE] = src_rxline[g];
         assign raw_src[`FIVM_SRC_PER_FR*g + `FIVM_BIT_SYNC_OVF] = src_sync_ovf[g];
      end
   endgenerate

   assign masked_src = raw_src & ~mask_all;

   always_comb begin
      state_next = state_reg;
      // status is level, re-sampled every cycle; one cycle of latency
      state_next.status = masked_src;
      state_next.rd_valid = rd_en;
      state_next.rdata = `FIVM_RDATA_IDLE;
      if (rd_en) begin
         case (rd_sel)
            FIVM_SEL_MASK_LO: state_next.rdata = mask_lo;
            FIVM_SEL_MASK_HI: state_next.rdata = mask_hi;
            FIVM_SEL_VEC_LO: state_next.rdata = state_reg.status[15:0];
            FIVM_SEL_VEC_HI: state_next.rdata = state_reg.status[31:16];
            // unmapped reads answer zero
            default: state_next.rdata = `FIVM_RDATA_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg.status <= 32'h00000000;
         state_reg.rdata <= `FIVM_RDATA_IDLE;
         state_reg.rd_valid <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign rd_valid = state_reg.rd_valid;
   assign vec_status = state_reg.status;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_wr_lo;
      wr_en && (addr == `FIVM_ADDR_MASK_LO);
   endsequence

   sequence s_wr_hi;
      wr_en && (addr == `FIVM_ADDR_MASK_HI);
   endsequence

   sequence s_rd(logic [11:0] a);
      rd_en && (addr == a);
   endsequence

   sequence s_wr_vec;
      wr_en && ((addr == `FIVM_ADDR_VEC_LO) || (addr == `FIVM_ADDR_VEC_HI));
   endsequence

   AST_MASK_ZERO: assert property ($past(rstn) |->
      ((vec_status & $past(mask_all)) == 32'h0))
      else $error("masked vector bit is set");
   AST_NAMED_MASKED: assert property (1'b1 |=>
      (!$past(fr1_hdlc_mask) || !fr1_hdlc_vector_status) &&
      (!$past(fr2_hdlc_mask) || !fr2_hdlc_vector_status) &&
      (!$past(fr6_elastic_mask) || !fr6_elastic_vector_status) &&
      (!$past(fr7_hdlc_mask) || !fr7_hdlc_vector_status))
      else $error("named vector bit set while masked");
   AST_UNMASKED_FOLLOW: assert property (1'b1 |=>
      vec_status == $past(raw_src & ~mask_all))
      else $error("vector status does not follow unmasked source");
   AST_FR2_FIELDS: assert property (s_wr_lo |=>
      {fr2_hdlc_mask, fr2_elastic_mask, fr2_rxline_mask, fr2_sync_ovf_mask}
      == $past(wdata[11:8]))
      else $error("framer 2 mask write lost");
   AST_FR1_FIELDS: assert property (s_wr_lo |=>
      {fr1_hdlc_mask, fr1_elastic_mask, fr1_rxline_mask, fr1_sync_ovf_mask}
      == $past(wdata[7:4]))
      else $error("framer 1 mask write lost");
   AST_FR0_FIELDS: assert property (s_wr_lo ##1 src_sync_ovf[0] |=>
      !fr0_sync_vector_status == $past(fr0_sync_ovf_mask))
      else $error("framer 0 sync mask not applied");
   AST_FR7_FIELDS: assert property (s_wr_hi |=>
      {fr7_hdlc_mask, fr7_elastic_mask, fr7_rxline_mask, fr7_sync_ovf_mask}
      == $past(wdata[15:12]))
      else $error("framer 7 mask write lost");
   AST_FR6_FIELDS: assert property (s_wr_hi |=>
      {fr6_hdlc_mask, fr6_elastic_mask} == $past(wdata[11:10]))
      else $error("framer 6 mask write lost");
   AST_FR3_FIELDS: assert property (s_wr_lo |=> mask_lo[15:12] == $past(wdata[15:12]))
      else $error("framer 3 mask write lost");
   AST_FR45_FIELDS: assert property (s_wr_hi |=> mask_hi[9:0] == $past(wdata[9:0]))
      else $error("framer 4-6 mask write lost");
   AST_HI_HOLD: assert property (!(wr_en && addr == `FIVM_ADDR_MASK_HI) |=>
      $stable(mask_hi))
      else $error("second mask changed without a write");
   AST_VEC_WR_IGNORED: assert property (s_wr_vec |=> $stable(mask_all))
      else $error("vector register write changed a mask");
   AST_VEC_LO_READ: assert property (s_rd(`FIVM_ADDR_VEC_LO) |=> rd_valid &&
      rdata[11:0] == $past(vec_status[11:0]))
      else $error("low vector read wrong");
   AST_VEC_HI_READ: assert property (s_rd(`FIVM_ADDR_VEC_HI) |=> rd_valid &&
      rdata[15:10] == $past(vec_status[31:26]))
      else $error("high vector read wrong");
   AST_MASK_READ: assert property (s_wr_hi ##1 s_rd(`FIVM_ADDR_MASK_HI) |=>
      rdata == $past(wdata, 2))
      else $error("mask readback wrong");
   AST_RD_VALID: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   AST_RD_IDLE: assert property (!rd_en |=> !rd_valid && (rdata == `FIVM_RDATA_IDLE))
      else $error("read answer outside its cycle");
   AST_RESET_CLEAR: assert property (disable iff (1'b0) $rose(rstn) |-> mask_all == 32'h0)
      else $error("masks not cleared by reset");

endmodule

// [rtl/fivm_defines.svh]
// addresses, field positions and reset values of the interrupt vector mask block
`ifndef FIVM_DEFINES_SVH
`define FIVM_DEFINES_SVH

`define FIVM_ADDR_W 12
`define FIVM_DATA_W 16
`define FIVM_ADDR_MASK_LO 12'h902
`define FIVM_ADDR_MASK_HI 12'h903
`define FIVM_ADDR_VEC_LO 12'h910
`define FIVM_ADDR_VEC_HI 12'h911
`define FIVM_MASK_RESET 16'h0000
`define FIVM_RDATA_IDLE 16'h0000
`define FIVM_FRAMERS 8
`define FIVM_SRC_PER_FR 4
`define FIVM_BIT_HDLC 3
`define FIVM_BIT_ELASTIC 2
`define FIVM_BIT_RXLINE 1
`define FIVM_BIT_SYNC_OVF 0

`endif

// [rtl/fivm_pkg.sv]
// types of the interrupt vector mask block
package fivm_pkg;

   typedef enum logic [2:0] {
      FIVM_SEL_NONE    = 3'b000,
      FIVM_SEL_MASK_LO = 3'b001,
      FIVM_SEL_MASK_HI = 3'b010,
      FIVM_SEL_VEC_LO  = 3'b011,
      FIVM_SEL_VEC_HI  = 3'b100
   } fivm_sel_t;

   typedef struct packed {
      logic [15:0] mask;
   } fivm_mask_state_t;

   typedef struct packed {
      logic [31:0] status;
      logic [15:0] rdata;
      logic rd_valid;
   } fivm_top_state_t;

endpackage

// [rtl/fivm_mask_reg.sv]
// one 16-bit vector mask register, host writable, clears on reset
`include "fivm_defines.svh"

module fivm_mask_reg (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // write port
   input wire logic wr,
   input wire logic [15:0] wdata,
   // stored mask
   output logic [15:0] mask
);
   import fivm_pkg::*;

   fivm_mask_state_t state_reg;
   fivm_mask_state_t state_next;

   always_comb begin
      state_next = state_reg;
      if (wr) begin
         state_next.mask = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg.mask <= `FIVM_MASK_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign mask = state_reg.mask;

endmodule

// [verification/fivm_host.sv]
// host processor model driving the register port of the mask block
module fivm_host (
   // clock
   input wire logic clk,
   // register port
   output logic [11:0] addr,
   output logic wr_en,
   output logic rd_en,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic rd_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr = 12'h000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wdata = 16'h0000;
   end
   // released lines show inverted values so stale data cannot pass as valid
   task automatic write(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   // write, then read the same address in the very next cycle
   task automatic write_read(input logic [11:0] a, input logic [15:0] wd,
      output logic [15:0] d, output logic v);
      @(posedge clk);
      #1;
      addr = a;
      wdata = wd;
      wr_en = 1'b1;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      wdata = ~wd;
      rd_en = 1'b1;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      addr = ~a;
      d = rdata;
      v = rd_valid;
   endtask
   task automatic read(input logic [11:0] a, output logic [15:0] d, output logic v);
      @(posedge clk);
      #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      addr = ~a;
      d = rdata;
      v = rd_valid;
   endtask
endmodule

// [verification/fivm_top_test.sv]
// self-checking bench for the framer interrupt vector mask block
module fivm_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] addr;
   logic wr_en;
   logic rd_en;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic rd_valid;
   logic [7:0] s_h = 8'hFF;
   logic [7:0] s_e = 8'hFF;
   logic [7:0] s_r = 8'hFF;
   logic [7:0] s_s = 8'hFF;
   logic [31:0] vec_status;
   logic [15:0] d;
   logic v;
   integer n_mismatch = 0;
   integer n_tests = 0;
   integer seed = 32'hCB9C0152;
   integer mlo = 0;
   integer mhi = 0;
   integer i;
   always #50 clk = ~clk;
   fivm_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
      .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .src_hdlc(s_h),
      .src_elastic(s_e), .src_rxline(s_r), .src_sync_ovf(s_s), .vec_status(vec_status));
   fivm_host host (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
      .rdata(rdata), .rd_valid(rd_valid));
   // reference: four sources per framer nibble, cleared where the mask is set
   function automatic logic [31:0] exp_vec();
      logic [31:0] e;
      for (int n = 0; n < 8; n++) begin
         e[4*n +: 4] = {s_h[n], s_e[n], s_r[n], s_s[n]};
      end
      return e & ~{mhi[15:0], mlo[15:0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // sources and masks show on the vector one edge after they are taken
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      host.read(a, d, v);
      chk({nm, " valid"}, 32'h1, {31'h0, v});
      chk(nm, e, {16'h0, d});
   endtask
   task automatic results();
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #500000;
      n_mismatch++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk);
      #1;
      chk("reset vec", 32'h0, vec_status);
      rstn = 1'b1;
      settle();
      chk("unmasked vec", exp_vec(), vec_status);
      rd(12'h902, 0, "mask lo reset");
      rd(12'h903, 0, "mask hi reset");
      // one mask bit at a time, all sources active
      for (i = 0; i < 32; i++) begin
         mlo = (i < 16) ? (1 << i) : 0;
         mhi = (i < 16) ? 0 : (1 << (i - 16));
         host.write(12'h902, mlo[15:0]);
         host.write(12'h903, mhi[15:0]);
         settle();
         chk("walk vec", exp_vec(), vec_status);
      end
      // random masks and sources; the vector register write must be ignored
      for (i = 0; i < 40; i++) begin
         mlo = $random(seed) & 16'hFFFF;
         mhi = $random(seed) & 16'hFFFF;
         {s_h, s_e, s_r, s_s} = $random(seed);
         host.write(12'h902, mlo[15:0]);
         host.write(12'h903, mhi[15:0]);
         host.write(12'h910, ~mlo[15:0]);
         settle();
         chk("vec", exp_vec(), vec_status);
         rd(12'h902, mlo, "mask lo");
         rd(12'h903, mhi, "mask hi");
         rd(12'h910, exp_vec() & 32'hFFFF, "vec lo");
         rd(12'h911, exp_vec() >> 16, "vec hi");
         rd(12'h904, 0, "unmapped");
      end
      // read the cycle after a write, then the answer must drop back to idle
      mlo = $random(seed) & 16'hFFFF;
      mhi = $random(seed) & 16'hFFFF;
      host.write_read(12'h902, mlo[15:0], d, v);
      chk("b2b lo", mlo, {16'h0, d});
      host.write_read(12'h903, mhi[15:0], d, v);
      chk("b2b hi", mhi, {16'h0, d});
      chk("b2b valid", 32'h1, {31'h0, v});
      @(posedge clk);
      #1;
      chk("idle valid", 32'h0, {31'h0, rd_valid});
      chk("idle rdata", 32'h0, {16'h0, rdata});
      // a reset in mid-run must clear the masks that were just written
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("reset2 vec", 32'h0, vec_status);
      rstn = 1'b1;
      mlo = 0;
      mhi = 0;
      settle();
      chk("reset2 unmasked", exp_vec(), vec_status);
      rd(12'h902, 0, "mask lo reset2");
      rd(12'h903, 0, "mask hi reset2");
      results();
   end
endmodule
